// File: common/sciopt_defines.svh
/*
 * Register offsets, field positions, reset values and event bit indices for the
 * serial option control block.
 * Assumes inclusion by bare name from sciopt_top and the testbench.
 */
`ifndef SCIOPT_DEFINES_SVH
`define SCIOPT_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SCIOPT_ADDR_OPT      3'h0
`define SCIOPT_ADDR_ENA      3'h1
`define SCIOPT_ADDR_IRQ_STS  3'h2
`define SCIOPT_ADDR_IRQ_MSK  3'h3
`define SCIOPT_ADDR_STATE    3'h4

// ----------------------------------------------------------------------
// option control fields
// ----------------------------------------------------------------------
`define SCIOPT_LOOP_BIT      7
`define SCIOPT_FREEZE_BIT    6
`define SCIOPT_RX_SOURCE_SELECT_BIT      5
`define SCIOPT_NINE_BIT      4
`define SCIOPT_WAKE_BIT      3
`define SCIOPT_IDLE_BIT      2
`define SCIOPT_PEN_BIT       1
`define SCIOPT_PODD_BIT      0

// ----------------------------------------------------------------------
// enable / interrupt control fields
// ----------------------------------------------------------------------
`define SCIOPT_TXE_IE_BIT    7
`define SCIOPT_TC_IE_BIT     6

// ----------------------------------------------------------------------
// sticky event bits
// ----------------------------------------------------------------------
`define SCIOPT_EV_TXE        0
`define SCIOPT_EV_TC         1
`define SCIOPT_EV_PERR       2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SCIOPT_OPT_RST       8'h00
`define SCIOPT_ENA_RST       8'h00
`define SCIOPT_STS_RST       3'h0
`define SCIOPT_MSK_RST       3'h0

`endif

// File: common/sciopt_pkg.sv
/*
 * Types shared by the serial option control design files.
 * Assumes sciopt_defines.svh is on the include path.
 */
package sciopt_pkg;

    // ------------------------------------------------------------------
    // line routing modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCIOPT_MODE_NORMAL = 3'h1,
        SCIOPT_MODE_LOOP   = 3'h2,
        SCIOPT_MODE_SINGLE = 3'h4
    } sciopt_mode_t;

    typedef logic [7:0] sciopt_byte_t;
    typedef logic [8:0] sciopt_char_t;

endpackage

// File: hdl/sciopt_parity.sv
/*
 * Parity generator and checker for 8- or 9-bit characters.
 * Assumes the character's most significant bit is the parity position.
 */
`timescale 1ns/1ps
`default_nettype none

module sciopt_parity
    import sciopt_pkg::*;
(
    input  wire logic         nine_bit,
    input  wire logic         odd_sel,
    input  wire sciopt_char_t tx_char,
    input  wire sciopt_char_t rx_char,
    output logic              gen_bit,
    output logic              check_fail
);

    sciopt_char_t lo_mask;
    sciopt_char_t full_mask;

    // ------------------------------------------------------------------
    // data bits below the parity position
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 9; i++) begin : g_mask
            assign lo_mask[i] = nine_bit ? (i < 8) : (i < 7);
            assign full_mask[i] = nine_bit ? 1'b1 : (i < 8);
        end
    endgenerate

    // total ones including parity must match odd_sel
    assign gen_bit = (^(tx_char & lo_mask)) ^ odd_sel;
    assign check_fail = (^(rx_char & full_mask)) != odd_sel;

endmodule

`default_nettype wire

// File: hdl/sciopt_top.sv
/*
 * Option and enable control for an asynchronous serial interface: line
 * routing, wait freeze, format selects, parity and transmit interrupts.
 * Assumes a single CORE_CLK domain; serializer signals are synchronous,
 * RXD_I and TXD_I come from pins.
 */
// Local design decisions: the strobed register port and the address map.
// Functional notes
// - loop bit set routes transmitter into receiver; clear uses separate pins.
// - freeze bit clear keeps serial clocks in wait; set freezes them.
// - receiver source bit matters only while loop bit is set.
// - loop with source clear is internal loop-back, no pin traffic.
// - loop with source set is single-wire on the transmit pin.
// - length bit clear gives start, eight data LSB first, stop.
// - length bit set adds a ninth data bit before stop.
// - wakeup bit selects idle-line at 0, address-mark at 1.
// - idle origin bit selects counting after start or after stop.
// - parity enable generates and checks parity in the MSB.
// - parity type selects even at 0, odd at 1.
// - transmit-empty enable requests interrupt while buffer-empty flag set.
// - transmit-done enable requests interrupt while done flag set.
// - option register reads back every written bit.
// - enable register is readable and writable at any time.
// - internal loop-back releases the transmit pin even when enabled.
`timescale 1ns/1ps
`default_nettype none
`include "sciopt_defines.svh"

module sciopt_top
    import sciopt_pkg::*;
(
    input  wire logic         CORE_CLK,
    input  wire logic         ARST_N,
    input  wire logic [2:0]   ADDR,
    input  wire sciopt_byte_t WDATA,
    input  wire logic         WR,
    input  wire logic         RD,
    output sciopt_byte_t      RDATA,
    input  wire logic         CPU_WAIT,
    input  wire logic         TX_ENABLE,
    input  wire logic         TX_DIR,
    input  wire logic         TX_SERIAL,
    input  wire logic         RXD_I,
    input  wire logic         TXD_I,
    output logic              TXD_O,
    output logic              TXD_OE,
    output logic              RX_SERIAL,
    output logic              SERIAL_CLK_EN,
    output logic              NINE_BIT_MODE,
    output logic              WAKE_ADDR_MARK,
    output logic              IDLE_AFTER_STOP,
    output logic [5:0]        OTHER_ENABLES,
    input  wire sciopt_char_t TX_CHAR,
    output sciopt_char_t      TX_FRAME_CHAR,
    input  wire sciopt_char_t RX_CHAR,
    input  wire logic         RX_CHAR_VALID,
    output logic              PARITY_ERR,
    input  wire logic         TX_BUF_EMPTY,
    input  wire logic         TX_DONE,
    output logic              TX_EMPTY_IRQ,
    output logic              TX_DONE_IRQ,
    output logic              IRQ
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    sciopt_byte_t opt_r, opt_nxt;
    sciopt_byte_t ena_r, ena_nxt;
    logic [2:0]   sts_r, sts_nxt;
    logic [2:0]   msk_r, msk_nxt;
    sciopt_byte_t rdata_r, rdata_nxt;
    logic [2:0]   events;
    sciopt_mode_t mode_r;

    always_comb begin
        opt_nxt = opt_r;
        ena_nxt = ena_r;
        msk_nxt = msk_r;
        rdata_nxt = 8'h00;
        // new events win over a same-cycle clear
        sts_nxt = sts_r | events;
        if (WR) begin
            case (ADDR)
                `SCIOPT_ADDR_OPT: begin
                    opt_nxt = WDATA;
                end
                `SCIOPT_ADDR_ENA: begin
                    ena_nxt = WDATA;
                end
                `SCIOPT_ADDR_IRQ_STS: begin
                    sts_nxt = (sts_r & ~WDATA[2:0]) | events;
                end
                `SCIOPT_ADDR_IRQ_MSK: begin
                    msk_nxt = WDATA[2:0];
                end
                default: begin
                    opt_nxt = opt_r;
                end
            endcase
        end
        if (RD) begin
            case (ADDR)
                `SCIOPT_ADDR_OPT:     rdata_nxt = opt_r;
                `SCIOPT_ADDR_ENA:     rdata_nxt = ena_r;
                `SCIOPT_ADDR_IRQ_STS: rdata_nxt = {5'h00, sts_r};
                `SCIOPT_ADDR_IRQ_MSK: rdata_nxt = {5'h00, msk_r};
                `SCIOPT_ADDR_STATE:   rdata_nxt = {5'h00, mode_r};
                default:              rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            opt_r   <= `SCIOPT_OPT_RST;
            ena_r   <= `SCIOPT_ENA_RST;
            sts_r   <= `SCIOPT_STS_RST;
            msk_r   <= `SCIOPT_MSK_RST;
            rdata_r <= 8'h00;
        end else begin
            opt_r   <= opt_nxt;
            ena_r   <= ena_nxt;
            sts_r   <= sts_nxt;
            msk_r   <= msk_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // a change counts only once stages two and three agree
    logic [2:0] rxd_sync_r, rxd_sync_nxt;
    logic [2:0] txd_sync_r, txd_sync_nxt;
    logic       rxd_filt_r, rxd_filt_nxt;
    logic       txd_filt_r, txd_filt_nxt;

    always_comb begin
        rxd_sync_nxt = {rxd_sync_r[1:0], RXD_I};
        txd_sync_nxt = {txd_sync_r[1:0], TXD_I};
        rxd_filt_nxt = rxd_filt_r;
        txd_filt_nxt = txd_filt_r;
        if (rxd_sync_r[1] == rxd_sync_r[2]) begin
            rxd_filt_nxt = rxd_sync_r[2];
        end
        if (txd_sync_r[1] == txd_sync_r[2]) begin
            txd_filt_nxt = txd_sync_r[2];
        end
    end

    // idle line is high, so the chain resets to ones
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rxd_sync_r <= 3'h7;
            txd_sync_r <= 3'h7;
            rxd_filt_r <= 1'b1;
            txd_filt_r <= 1'b1;
        end else begin
            rxd_sync_r <= rxd_sync_nxt;
            txd_sync_r <= txd_sync_nxt;
            rxd_filt_r <= rxd_filt_nxt;
            txd_filt_r <= txd_filt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // routing mode and line steering
    // ------------------------------------------------------------------
    sciopt_mode_t mode_nxt;
    logic         rx_ser_r, rx_ser_nxt;
    logic         txd_o_r, txd_o_nxt;
    logic         txd_oe_r, txd_oe_nxt;

    always_comb begin
        mode_nxt = SCIOPT_MODE_NORMAL;
        if (opt_r[`SCIOPT_LOOP_BIT]) begin
            // source select is ignored outside loop modes
            mode_nxt = opt_r[`SCIOPT_RX_SOURCE_SELECT_BIT] ? SCIOPT_MODE_SINGLE
                                               : SCIOPT_MODE_LOOP;
        end
        rx_ser_nxt = rxd_filt_r;
        txd_o_nxt  = 1'b1;
        txd_oe_nxt = 1'b0;
        case (mode_r)
            SCIOPT_MODE_NORMAL: begin
                rx_ser_nxt = rxd_filt_r;
                txd_o_nxt  = TX_SERIAL;
                txd_oe_nxt = TX_ENABLE;
            end
            SCIOPT_MODE_LOOP: begin
                rx_ser_nxt = TX_SERIAL;
                txd_o_nxt  = 1'b1;
                txd_oe_nxt = 1'b0;
            end
            SCIOPT_MODE_SINGLE: begin
                // direction input turns the shared wire around
                txd_o_nxt  = TX_SERIAL;
                txd_oe_nxt = TX_ENABLE & TX_DIR;
                rx_ser_nxt = txd_oe_nxt ? TX_SERIAL : txd_filt_r;
            end
            default: begin
                rx_ser_nxt = 1'b1;
                txd_o_nxt  = 1'b1;
                txd_oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_r   <= SCIOPT_MODE_NORMAL;
            rx_ser_r <= 1'b1;
            txd_o_r  <= 1'b1;
            txd_oe_r <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            rx_ser_r <= rx_ser_nxt;
            txd_o_r  <= txd_o_nxt;
            txd_oe_r <= txd_oe_nxt;
        end
    end

    assign RX_SERIAL = rx_ser_r;
    assign TXD_O     = txd_o_r;
    assign TXD_OE    = txd_oe_r;

    // ------------------------------------------------------------------
    // format, wakeup and clock selects
    // ------------------------------------------------------------------
    logic       clk_en_r, clk_en_nxt;
    logic [2:0] fmt_r, fmt_nxt;
    logic [5:0] oth_r, oth_nxt;

    always_comb begin
        clk_en_nxt = !(CPU_WAIT && opt_r[`SCIOPT_FREEZE_BIT]);
        fmt_nxt[2] = opt_r[`SCIOPT_NINE_BIT];
        fmt_nxt[1] = opt_r[`SCIOPT_WAKE_BIT];
        fmt_nxt[0] = opt_r[`SCIOPT_IDLE_BIT];
        oth_nxt    = ena_r[5:0];
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clk_en_r <= 1'b1;
            fmt_r    <= 3'h0;
            oth_r    <= 6'h00;
        end else begin
            clk_en_r <= clk_en_nxt;
            fmt_r    <= fmt_nxt;
            oth_r    <= oth_nxt;
        end
    end

    assign SERIAL_CLK_EN   = clk_en_r;
    assign NINE_BIT_MODE   = fmt_r[2];
    assign WAKE_ADDR_MARK  = fmt_r[1];
    assign IDLE_AFTER_STOP = fmt_r[0];
    assign OTHER_ENABLES   = oth_r;

    // ------------------------------------------------------------------
    // parity generation and checking
    // ------------------------------------------------------------------
    logic         par_bit;
    logic         par_fail;
    sciopt_char_t frame_r, frame_nxt;
    logic         perr_r, perr_nxt;

    sciopt_parity sciopt_parity_inst (
        .nine_bit   (opt_r[`SCIOPT_NINE_BIT]),
        .odd_sel    (opt_r[`SCIOPT_PODD_BIT]),
        .tx_char    (TX_CHAR),
        .rx_char    (RX_CHAR),
        .gen_bit    (par_bit),
        .check_fail (par_fail)
    );

    always_comb begin
        frame_nxt = TX_CHAR;
        if (opt_r[`SCIOPT_PEN_BIT]) begin
            if (opt_r[`SCIOPT_NINE_BIT]) begin
                frame_nxt[8] = par_bit;
            end else begin
                frame_nxt[7] = par_bit;
                frame_nxt[8] = 1'b0;
            end
        end
        perr_nxt = RX_CHAR_VALID && opt_r[`SCIOPT_PEN_BIT] && par_fail;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            frame_r <= 9'h000;
            perr_r  <= 1'b0;
        end else begin
            frame_r <= frame_nxt;
            perr_r  <= perr_nxt;
        end
    end

    assign TX_FRAME_CHAR = frame_r;
    assign PARITY_ERR    = perr_r;

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic txe_d_r, txe_d_nxt;
    logic tc_d_r, tc_d_nxt;
    logic txe_irq_r, txe_irq_nxt;
    logic tc_irq_r, tc_irq_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        txe_d_nxt = TX_BUF_EMPTY;
        tc_d_nxt  = TX_DONE;
        events[`SCIOPT_EV_TXE]  = TX_BUF_EMPTY && !txe_d_r;
        events[`SCIOPT_EV_TC]   = TX_DONE && !tc_d_r;
        events[`SCIOPT_EV_PERR] = perr_nxt;
        // level requests follow the flags, not the sticky copies
        txe_irq_nxt = ena_r[`SCIOPT_TXE_IE_BIT] && TX_BUF_EMPTY;
        tc_irq_nxt  = ena_r[`SCIOPT_TC_IE_BIT] && TX_DONE;
        irq_nxt     = |(sts_nxt & msk_nxt);
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            txe_d_r   <= 1'b0;
            tc_d_r    <= 1'b0;
            txe_irq_r <= 1'b0;
            tc_irq_r  <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            txe_d_r   <= txe_d_nxt;
            tc_d_r    <= tc_d_nxt;
            txe_irq_r <= txe_irq_nxt;
            tc_irq_r  <= tc_irq_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign TX_EMPTY_IRQ = txe_irq_r;
    assign TX_DONE_IRQ  = tc_irq_r;
    assign IRQ          = irq_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_opt_write;
        WR && ADDR == `SCIOPT_ADDR_OPT;
    endsequence

    sequence s_opt_read;
        RD && ADDR == `SCIOPT_ADDR_OPT;
    endsequence

    a_normal_rx_path: assert property (mode_r == SCIOPT_MODE_NORMAL |=>
        RX_SERIAL == $past(rxd_filt_r))
        else $error("normal mode receive path wrong");
    a_wait_freeze: assert property (CPU_WAIT && opt_r[`SCIOPT_FREEZE_BIT] |=>
        !SERIAL_CLK_EN)
        else $error("serial clock not frozen in wait");
    a_rx_source_select_ignored: assert property (!$past(opt_r[`SCIOPT_LOOP_BIT]) |->
        mode_r == SCIOPT_MODE_NORMAL)
        else $error("source select acted without loop");
    a_loop_internal: assert property (mode_r == SCIOPT_MODE_LOOP |=>
        RX_SERIAL == $past(TX_SERIAL) && !TXD_OE)
        else $error("internal loop-back not internal");
    a_single_wire: assert property (mode_r == SCIOPT_MODE_SINGLE && TX_ENABLE
        && TX_DIR |=> TXD_OE && TXD_O == $past(TX_SERIAL))
        else $error("single-wire drive wrong");
    a_loop_pin_free: assert property (opt_r[`SCIOPT_LOOP_BIT] &&
        !opt_r[`SCIOPT_RX_SOURCE_SELECT_BIT] ##1 opt_r[`SCIOPT_LOOP_BIT] |=> !TXD_OE)
        else $error("transmit pin held in loop-back");
    a_format_select: assert property ($stable(opt_r) |=>
        NINE_BIT_MODE == $past(opt_r[`SCIOPT_NINE_BIT])
        && WAKE_ADDR_MARK == $past(opt_r[`SCIOPT_WAKE_BIT])
        && IDLE_AFTER_STOP == $past(opt_r[`SCIOPT_IDLE_BIT]))
        else $error("format select output stale");
    a_parity_off: assert property (!opt_r[`SCIOPT_PEN_BIT] |=>
        !PARITY_ERR && TX_FRAME_CHAR == $past(TX_CHAR))
        else $error("parity active while disabled");
    a_parity_type: assert property (opt_r[`SCIOPT_PEN_BIT] &&
        !opt_r[`SCIOPT_NINE_BIT] && $stable(opt_r) |=>
        (^TX_FRAME_CHAR[7:0]) == $past(opt_r[`SCIOPT_PODD_BIT]))
        else $error("generated parity type wrong");
    a_txe_request: assert property (TX_BUF_EMPTY && ena_r[`SCIOPT_TXE_IE_BIT]
        |=> TX_EMPTY_IRQ)
        else $error("transmit-empty request missing");
    a_tc_request: assert property (TX_DONE_IRQ |->
        $past(TX_DONE) && $past(ena_r[`SCIOPT_TC_IE_BIT]))
        else $error("transmit-done request without cause");
    a_opt_readback: assert property (s_opt_write ##1 !WR ##1 s_opt_read |=>
        RDATA == $past(WDATA, 3))
        else $error("option register readback mismatch");
    a_ena_any_time: assert property (WR && ADDR == `SCIOPT_ADDR_ENA |=>
        ena_r == $past(WDATA))
        else $error("enable register write lost");
    a_event_wins: assert property (events != 3'h0 && WR &&
        ADDR == `SCIOPT_ADDR_IRQ_STS |=> (sts_r & $past(events)) == $past(events))
        else $error("event lost under clear");

endmodule

`default_nettype wire

// File: tb/sciopt_remote.sv
/*
 * Remote serial device: sends frames on the receive line and can drive
 * the shared transmit wire in single-wire mode.
 * Assumes the bench clock and 8 clocks a bit time.
 */
`timescale 1ns/1ps
`default_nettype none

module sciopt_remote (
    input  wire logic clk,
    input  wire logic txd_o,
    input  wire logic txd_oe,
    output logic      rxd_i,
    output logic      txd_i
);
    logic rx_line = 1'b1;
    logic w_en    = 1'b0;
    logic w_val   = 1'b1;

    // pull-up keeps the shared wire high while nobody drives it
    assign txd_i = txd_oe ? txd_o : (w_en ? w_val : 1'b1);
    assign rxd_i = rx_line;

    task automatic drive_wire(input logic en, input logic val);
        @(posedge clk);
        w_en  <= en;
        w_val <= val;
    endtask

    // ------------------------------------------------------------------
    // frame sender: start, data LSB first, ninth bit if asked, stop
    // ------------------------------------------------------------------
    task automatic send_char(input logic [8:0] c, input logic nine);
        logic [10:0] f;
        f = nine ? {1'b1, c, 1'b0} : {2'b11, c[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(posedge clk);
            rx_line <= f[i];
            repeat (7) @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// File: tb/sci_option_control_bench.sv
/*
 * Self-checking bench for the serial option control block.
 * Assumes sciopt_top and the remote model; one 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sciopt_defines.svh"

module sci_option_control_bench
    import sciopt_pkg::*;
;
    logic         CORE_CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0;
    logic         CPU_WAIT = 1'b0, TX_ENABLE = 1'b0, TX_DIR = 1'b0, TX_SERIAL = 1'b1;
    logic         RX_CHAR_VALID = 1'b0, TX_BUF_EMPTY = 1'b0, TX_DONE = 1'b0;
    logic [2:0]   ADDR = 3'h0;
    sciopt_byte_t WDATA = 8'h00, RDATA;
    sciopt_char_t TX_CHAR = 9'h000, RX_CHAR = 9'h000, TX_FRAME_CHAR;
    logic         RXD_I, TXD_I, TXD_O, TXD_OE, RX_SERIAL, SERIAL_CLK_EN, NINE_BIT_MODE;
    logic         WAKE_ADDR_MARK, IDLE_AFTER_STOP, PARITY_ERR, TX_EMPTY_IRQ, TX_DONE_IRQ, IRQ;
    logic [5:0]   OTHER_ENABLES;
    int           fail_count = 0;
    int           compares = 0;

    sciopt_top sciopt_top_inst (.CORE_CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .CPU_WAIT, .TX_ENABLE, .TX_DIR, .TX_SERIAL, .RXD_I, .TXD_I, .TXD_O, .TXD_OE,
        .RX_SERIAL, .SERIAL_CLK_EN, .NINE_BIT_MODE, .WAKE_ADDR_MARK, .IDLE_AFTER_STOP,
        .OTHER_ENABLES, .TX_CHAR, .TX_FRAME_CHAR, .RX_CHAR, .RX_CHAR_VALID, .PARITY_ERR,
        .TX_BUF_EMPTY, .TX_DONE, .TX_EMPTY_IRQ, .TX_DONE_IRQ, .IRQ);

    sciopt_remote sciopt_remote_inst (.clk(CORE_CLK), .txd_o(TXD_O), .txd_oe(TXD_OE),
        .rxd_i(RXD_I), .txd_i(TXD_I));

    initial forever #50 CORE_CLK = ~CORE_CLK;

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input sciopt_byte_t d);
        @(posedge CORE_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CORE_CLK);
        WR    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input sciopt_byte_t exp, input string what);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CORE_CLK);
        RD   <= 1'b0;
        #1;
        chk(what, {1'b0, exp}, {1'b0, RDATA});
    endtask

    // sample mid-bit, leaving room for the pin synchroniser delay
    task automatic frame(input logic [8:0] c, input logic nine);
        logic [10:0] f;
        f = nine ? {1'b1, c, 1'b0} : {2'b11, c[7:0], 1'b0};
        fork
            sciopt_remote_inst.send_char(c, nine);
            begin
                step(10);
                for (int i = 0; i < (nine ? 11 : 10); i++) begin
                    chk("rx_bit", {8'h00, f[i]}, {8'h00, RX_SERIAL});
                    step(8);
                end
            end
        join
    endtask

    task automatic rx_char(input sciopt_char_t c, input logic exp);
        @(posedge CORE_CLK);
        RX_CHAR       <= c;
        RX_CHAR_VALID <= 1'b1;
        @(posedge CORE_CLK);
        RX_CHAR_VALID <= 1'b0;
        #1;
        chk("perr", {8'h00, exp}, {8'h00, PARITY_ERR});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(`SCIOPT_ADDR_OPT, 8'h00, "opt_rst");
        rd(`SCIOPT_ADDR_ENA, 8'h00, "ena_rst");
        wr(`SCIOPT_ADDR_OPT, 8'h5A);
        rd(`SCIOPT_ADDR_OPT, 8'h5A, "opt");
        chk("fmt", 9'h006, {6'h00, NINE_BIT_MODE, WAKE_ADDR_MARK, IDLE_AFTER_STOP});
        wr(`SCIOPT_ADDR_OPT, 8'h25);
        rd(`SCIOPT_ADDR_OPT, 8'h25, "opt");
        chk("fmt", 9'h001, {6'h00, NINE_BIT_MODE, WAKE_ADDR_MARK, IDLE_AFTER_STOP});
        wr(`SCIOPT_ADDR_ENA, 8'hFF);
        rd(`SCIOPT_ADDR_ENA, 8'hFF, "ena");
        chk("other", 9'h03F, {3'h0, OTHER_ENABLES});
        wr(`SCIOPT_ADDR_ENA, 8'h00);
        wr(3'h6, 8'hFF);
        rd(3'h6, 8'h00, "unmapped");
        $display("test regs done");
    endtask

    task automatic t_route;
        @(posedge CORE_CLK);
        TX_ENABLE <= 1'b1;
        TX_SERIAL <= 1'b0;
        step(3);
        chk("oe", 9'h001, {8'h00, TXD_OE});
        chk("txd", 9'h000, {8'h00, TXD_O});
        rd(`SCIOPT_ADDR_STATE, 8'h01, "mode");
        frame(9'h0B4, 1'b0);
        wr(`SCIOPT_ADDR_OPT, 8'h10);
        frame(9'h14B, 1'b1);
        wr(`SCIOPT_ADDR_OPT, 8'h80);
        step(3);
        chk("oe", 9'h000, {8'h00, TXD_OE});
        chk("loop", 9'h000, {8'h00, RX_SERIAL});
        rd(`SCIOPT_ADDR_STATE, 8'h02, "mode");
        wr(`SCIOPT_ADDR_OPT, 8'hA0);
        @(posedge CORE_CLK);
        TX_DIR    <= 1'b1;
        TX_SERIAL <= 1'b1;
        step(3);
        chk("oe", 9'h001, {8'h00, TXD_OE});
        chk("txd", 9'h001, {8'h00, TXD_O});
        rd(`SCIOPT_ADDR_STATE, 8'h04, "mode");
        @(posedge CORE_CLK);
        TX_DIR <= 1'b0;
        sciopt_remote_inst.drive_wire(1'b1, 1'b0);
        step(8);
        chk("oe", 9'h000, {8'h00, TXD_OE});
        chk("wire", 9'h000, {8'h00, RX_SERIAL});
        sciopt_remote_inst.drive_wire(1'b0, 1'b1);
        wr(`SCIOPT_ADDR_OPT, 8'h00);
        $display("test route done");
    endtask

    task automatic t_freeze;
        @(posedge CORE_CLK);
        CPU_WAIT <= 1'b1;
        step(2);
        chk("clk_en", 9'h001, {8'h00, SERIAL_CLK_EN});
        wr(`SCIOPT_ADDR_OPT, 8'h40);
        step(2);
        chk("clk_en", 9'h000, {8'h00, SERIAL_CLK_EN});
        @(posedge CORE_CLK);
        CPU_WAIT <= 1'b0;
        step(2);
        chk("clk_en", 9'h001, {8'h00, SERIAL_CLK_EN});
        $display("test freeze done");
    endtask

    task automatic t_parity;
        sciopt_byte_t opt[5] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13};
        sciopt_char_t exp[5] = '{9'h107, 9'h087, 9'h007, 9'h107, 9'h007};
        @(posedge CORE_CLK);
        TX_CHAR <= 9'h107;
        for (int i = 0; i < 5; i++) begin
            wr(`SCIOPT_ADDR_OPT, opt[i]);
            step(3);
            chk("frame", exp[i], TX_FRAME_CHAR);
        end
        wr(`SCIOPT_ADDR_OPT, 8'h02);
        rx_char(9'h001, 1'b1);
        rx_char(9'h003, 1'b0);
        wr(`SCIOPT_ADDR_OPT, 8'h03);
        rx_char(9'h003, 1'b1);
        rx_char(9'h001, 1'b0);
        wr(`SCIOPT_ADDR_OPT, 8'h00);
        rx_char(9'h001, 1'b0);
        $display("test parity done");
    endtask

    task automatic t_irq;
        wr(`SCIOPT_ADDR_IRQ_STS, 8'h07);
        wr(`SCIOPT_ADDR_IRQ_MSK, 8'h01);
        wr(`SCIOPT_ADDR_ENA, 8'h80);
        @(posedge CORE_CLK);
        TX_BUF_EMPTY <= 1'b1;
        step(3);
        chk("txe_irq", 9'h001, {8'h00, TX_EMPTY_IRQ});
        chk("irq", 9'h001, {8'h00, IRQ});
        rd(`SCIOPT_ADDR_IRQ_STS, 8'h01, "sts");
        wr(`SCIOPT_ADDR_IRQ_STS, 8'h01);
        step(1);
        chk("irq", 9'h000, {8'h00, IRQ});
        wr(`SCIOPT_ADDR_ENA, 8'h40);
        step(2);
        chk("txe_irq", 9'h000, {8'h00, TX_EMPTY_IRQ});
        fork
            begin
                @(posedge CORE_CLK);
                TX_DONE <= 1'b1;
            end
            wr(`SCIOPT_ADDR_IRQ_STS, 8'h02);
        join
        step(3);
        rd(`SCIOPT_ADDR_IRQ_STS, 8'h02, "sts");
        chk("tc_irq", 9'h001, {8'h00, TX_DONE_IRQ});
        chk("irq", 9'h000, {8'h00, IRQ});
        wr(`SCIOPT_ADDR_ENA, 8'h00);
        step(2);
        chk("tc_irq", 9'h000, {8'h00, TX_DONE_IRQ});
        $display("test irq done");
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #5000000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        t_regs();
        t_route();
        t_freeze();
        t_parity();
        t_irq();
        finish_test();
    end
endmodule

`default_nettype wire
